// ==== inc/msgq_pkg.sv ====
// message queue unit constants: port offsets, status/mask offsets, reset values
// assumes a simple synchronous register port with read and write strobes
package msgq_pkg;
    localparam logic [11:0] HOST_STAT_OFS  = 12'h030;
    localparam logic [11:0] HOST_MASK_OFS  = 12'h034;
    localparam logic [11:0] LOCAL_STAT_OFS = 12'h038;
    localparam logic [11:0] LOCAL_MASK_OFS = 12'h03C;
    localparam logic [11:0] PORT_IFPP_OFS  = 12'h040;
    localparam logic [11:0] PORT_OPFP_OFS  = 12'h044;
    localparam logic [11:0] PORT_IPFP_OFS  = 12'h048;
    localparam logic [11:0] PORT_OFPP_OFS  = 12'h04C;
    localparam logic [31:0] EMPTY_WORD     = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_FILL      = 32'hFFFF_FFFE;
    localparam logic        MASK_RESET     = 1'h1;
    localparam int          FIFO_DEPTH     = 32;
    localparam int          DATA_W         = 32;
    // queue indices
    localparam int          Q_IN_FREE      = 0;
    localparam int          Q_IN_POST      = 1;
    localparam int          Q_OUT_POST     = 2;
    localparam int          Q_OUT_FREE     = 3;
endpackage

// ==== logic/message_queue_fifo_ports.sv ====
// message queue unit: four fifos behind four shared ports, plus status and mask
// assumes reg_rd_in/reg_wr_in are single-cycle strobes on core_clk_in
`timescale 1ns/1ps

module msg_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } fifo_s;
    fifo_s st_r;
    fifo_s st_nxt;
    logic  push;
    logic  pop;

    assign in_ready_out  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (st_r.cnt != '0);
    assign out_data_out  = st_r.mem[st_r.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop  = out_ready_in && out_valid_out;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wp] = in_data_in;
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// Summary of operation
// - port 0x40 read pops inbound free, write pushes inbound post.
// - port 0x44 read pops outbound post, write pushes outbound free.
// - port 0x48 read pops inbound post, write pushes inbound free.
// - port 0x4C read pops outbound free, write pushes outbound post.
// - each port is one 32-bit location reaching two different queues.
// - reading an empty queue returns all ones, queue unchanged.
// - writing a full queue is discarded, queue unchanged.
// - every queue starts empty.
// - reset flushes all four queues.
// - host status bit shows outbound post not empty; resets to zero.
// - local status bit shows inbound post not empty; resets to zero.
// - mask bits reset to one; cleared mask lets status raise interrupt.
module message_queue_fifo_ports #(
    parameter int DEPTH = msgq_pkg::FIFO_DEPTH
) (
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic [11:0] reg_addr_in,
    input  wire logic        reg_rd_in,
    input  wire logic        reg_wr_in,
    input  wire logic [31:0] reg_wdata_in,
    output logic      [31:0] reg_rdata_out,
    output logic             host_irq_out,
    output logic             local_irq_out
);
    typedef struct packed {
        logic [31:0] rdata;
        logic        host_mask;
        logic        local_mask;
        logic        host_stat;
        logic        local_stat;
        logic        host_irq;
        logic        local_irq;
    } top_s;
    top_s st_r;
    top_s st_nxt;

    logic [3:0]        q_push;
    logic [3:0]        q_pop;
    logic [3:0]        q_ready;
    logic [3:0]        q_valid;
    logic [3:0][31:0]  q_data;
    logic [1:0]        rd_q;
    logic [1:0]        wr_q;
    logic              port_hit;

    // port decode: read queue and write queue per shared location
    always_comb begin
        port_hit = 1'b1;
        rd_q = 2'(msgq_pkg::Q_IN_FREE);
        wr_q = 2'(msgq_pkg::Q_IN_POST);
        case (reg_addr_in)
            msgq_pkg::PORT_IFPP_OFS: begin
                rd_q = 2'(msgq_pkg::Q_IN_FREE);
                wr_q = 2'(msgq_pkg::Q_IN_POST);
            end
            msgq_pkg::PORT_OPFP_OFS: begin
                rd_q = 2'(msgq_pkg::Q_OUT_POST);
                wr_q = 2'(msgq_pkg::Q_OUT_FREE);
            end
            msgq_pkg::PORT_IPFP_OFS: begin
                rd_q = 2'(msgq_pkg::Q_IN_POST);
                wr_q = 2'(msgq_pkg::Q_IN_FREE);
            end
            msgq_pkg::PORT_OFPP_OFS: begin
                rd_q = 2'(msgq_pkg::Q_OUT_FREE);
                wr_q = 2'(msgq_pkg::Q_OUT_POST);
            end
            default: begin
                port_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        q_push = '0;
        q_pop  = '0;
        if (port_hit && reg_wr_in) begin
            q_push[wr_q] = 1'b1;
        end
        if (port_hit && reg_rd_in) begin
            q_pop[rd_q] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_q
            msg_fifo #(
                .WIDTH (msgq_pkg::DATA_W),
                .DEPTH (DEPTH)
            ) u_fifo (
                .core_clk_in   (core_clk_in),
                .rst_in        (rst_in),
                .in_valid_in   (q_push[g]),
                .in_ready_out  (q_ready[g]),
                .in_data_in    (reg_wdata_in),
                .out_valid_out (q_valid[g]),
                .out_ready_in  (q_pop[g]),
                .out_data_out  (q_data[g])
            );
        end
    endgenerate

    always_comb begin
        st_nxt = st_r;
        st_nxt.host_stat  = q_valid[msgq_pkg::Q_OUT_POST];
        st_nxt.local_stat = q_valid[msgq_pkg::Q_IN_POST];
        st_nxt.host_irq   = st_nxt.host_stat && !st_r.host_mask;
        st_nxt.local_irq  = st_nxt.local_stat && !st_r.local_mask;
        if (reg_wr_in && reg_addr_in == msgq_pkg::HOST_MASK_OFS) begin
            st_nxt.host_mask = reg_wdata_in[0];
        end
        if (reg_wr_in && reg_addr_in == msgq_pkg::LOCAL_MASK_OFS) begin
            st_nxt.local_mask = reg_wdata_in[0];
        end
        if (reg_rd_in) begin
            if (port_hit) begin
                st_nxt.rdata = q_valid[rd_q] ? q_data[rd_q] : msgq_pkg::EMPTY_WORD;
            end else begin
                case (reg_addr_in)
                    msgq_pkg::HOST_STAT_OFS:  st_nxt.rdata = {31'h0, st_r.host_stat};
                    msgq_pkg::LOCAL_STAT_OFS: st_nxt.rdata = {31'h0, st_r.local_stat};
                    msgq_pkg::HOST_MASK_OFS:
                        st_nxt.rdata = msgq_pkg::MASK_FILL | {31'h0, st_r.host_mask};
                    msgq_pkg::LOCAL_MASK_OFS:
                        st_nxt.rdata = msgq_pkg::MASK_FILL | {31'h0, st_r.local_mask};
                    default:                  st_nxt.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
            st_r.host_mask  <= msgq_pkg::MASK_RESET;
            st_r.local_mask <= msgq_pkg::MASK_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign host_irq_out  = st_r.host_irq;
    assign local_irq_out = st_r.local_irq;

    // checks
    chk_empty_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        reg_rd_in && port_hit && !q_valid[rd_q] |=> reg_rdata_out == msgq_pkg::EMPTY_WORD)
        else $error("empty read not all ones");
    chk_full_drop: assert property (@(posedge core_clk_in) disable iff (rst_in)
        q_push[0] && !q_ready[0] && !q_pop[0] |=> !q_ready[0])
        else $error("full queue changed on write");
    chk_host_stat: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ##1 st_r.host_stat == $past(q_valid[msgq_pkg::Q_OUT_POST]))
        else $error("host status wrong");
    chk_local_stat: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ##1 st_r.local_stat == $past(q_valid[msgq_pkg::Q_IN_POST]))
        else $error("local status wrong");
    chk_mask_gate: assert property (@(posedge core_clk_in) disable iff (rst_in)
        st_r.host_mask |=> !host_irq_out)
        else $error("masked host irq raised");
    chk_pop_only_read: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(q_valid[msgq_pkg::Q_IN_POST]) |->
            $past(reg_rd_in) && $past(reg_addr_in) == msgq_pkg::PORT_IPFP_OFS)
        else $error("pop without read");
    chk_post_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == msgq_pkg::PORT_IFPP_OFS |-> q_push == 4'h2)
        else $error("inbound post push misrouted");
    chk_ob_route: assert property (@(posedge core_clk_in) disable iff (rst_in)
        reg_wr_in && reg_addr_in == msgq_pkg::PORT_OFPP_OFS |-> q_push == 4'h4)
        else $error("outbound post push misrouted");
    chk_empty_start: assert property (@(posedge core_clk_in)
        $fell(rst_in) |-> q_valid == 4'h0)
        else $error("queue not empty after reset");
    cov_post_read: cover property (@(posedge core_clk_in) reg_rd_in && port_hit && q_valid[rd_q]);
    cov_full: cover property (@(posedge core_clk_in) q_push[1] && !q_ready[1]);
    cov_host_irq: cover property (@(posedge core_clk_in) host_irq_out);
endmodule

// ==== testbench/message_queue_fifo_ports_tb.sv ====
// bench for the message queue unit: port pairing, order, empty/full, status, flush
// assumes the strobe register port, read data one cycle after the strobe
`timescale 1ns/1ps

module message_queue_fifo_ports_tb;
    localparam int DEPTH = 4;
    logic        core_clk_in;
    logic        rst_in;
    logic [11:0] reg_addr;
    logic        reg_rd;
    logic        reg_wr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        host_irq;
    logic        local_irq;
    int          err_total;
    int          checks_done;
    logic [11:0] wr_port [4];
    logic [11:0] rd_port [4];

    message_queue_fifo_ports #(.DEPTH(DEPTH)) dut_u (
        .core_clk_in  (core_clk_in),
        .rst_in       (rst_in),
        .reg_addr_in  (reg_addr),
        .reg_rd_in    (reg_rd),
        .reg_wr_in    (reg_wr),
        .reg_wdata_in (reg_wdata),
        .reg_rdata_out(reg_rdata),
        .host_irq_out (host_irq),
        .local_irq_out(local_irq)
    );

    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one cycle of the port; strobes set once per time step
    task automatic acc(input logic r, input logic w, input logic [11:0] a, input logic [31:0] d);
        reg_rd    = r;
        reg_wr    = w;
        reg_addr  = a;
        reg_wdata = d;
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) begin
            acc(1'b0, 1'b0, 12'h000, 32'h0000_0000);
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        acc(1'b1, 1'b0, a, 32'h0000_0000);
        chk(reg_rdata, exp, what);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // empty ports, status, masks and irq pins after a reset
    task automatic reset_state;
        chk({30'h0, host_irq, local_irq}, 32'h0000_0000, "irq pins");
        rd(msgq_pkg::HOST_STAT_OFS, 32'h0000_0000, "host status");
        rd(msgq_pkg::LOCAL_STAT_OFS, 32'h0000_0000, "local status");
        rd(msgq_pkg::HOST_MASK_OFS, 32'hFFFF_FFFF, "host mask");
        rd(msgq_pkg::LOCAL_MASK_OFS, 32'hFFFF_FFFF, "local mask");
        for (int i = 0; i < 4; i++) begin
            rd(rd_port[i], msgq_pkg::EMPTY_WORD, "empty");
        end
        idle(1);
    endtask

    initial begin
        wr_port = '{msgq_pkg::PORT_IFPP_OFS, msgq_pkg::PORT_OPFP_OFS,
                    msgq_pkg::PORT_IPFP_OFS, msgq_pkg::PORT_OFPP_OFS};
        rd_port = '{msgq_pkg::PORT_IPFP_OFS, msgq_pkg::PORT_OFPP_OFS,
                    msgq_pkg::PORT_IFPP_OFS, msgq_pkg::PORT_OPFP_OFS};
        err_total   = 0;
        checks_done = 0;
        rst_in      = 1'b1;
        reg_rd      = 1'b0;
        reg_wr      = 1'b0;
        reg_addr    = 12'h000;
        reg_wdata   = 32'h0000_0000;
        repeat (6) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        reset_state();
        rd(12'h100, 32'h0000_0000, "unmapped");
        $display("test reset_state done");
        // fill one past depth, drain in order, then empty
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k <= DEPTH; k++) begin
                acc(1'b0, 1'b1, wr_port[p], {8'hA5, 8'(p), 8'h00, 8'(k)});
            end
            rd(wr_port[p], msgq_pkg::EMPTY_WORD, "other queue");
            for (int k = 0; k < DEPTH; k++) begin
                rd(rd_port[p], {8'hA5, 8'(p), 8'h00, 8'(k)}, "order");
            end
            rd(rd_port[p], msgq_pkg::EMPTY_WORD, "drained");
        end
        $display("test port_fifo done");
        acc(1'b0, 1'b1, msgq_pkg::PORT_OFPP_OFS, 32'h1234_5678);
        acc(1'b0, 1'b1, msgq_pkg::PORT_IFPP_OFS, 32'h8765_4321);
        idle(3);
        chk({30'h0, host_irq, local_irq}, 32'h0000_0000, "masked irq");
        rd(msgq_pkg::HOST_STAT_OFS, 32'h0000_0001, "host status");
        rd(msgq_pkg::LOCAL_STAT_OFS, 32'h0000_0001, "local status");
        acc(1'b0, 1'b1, msgq_pkg::HOST_MASK_OFS, 32'h0000_0000);
        acc(1'b0, 1'b1, msgq_pkg::LOCAL_MASK_OFS, 32'h0000_0000);
        idle(3);
        chk({30'h0, host_irq, local_irq}, 32'h0000_0003, "unmasked irq");
        rd(msgq_pkg::HOST_MASK_OFS, msgq_pkg::MASK_FILL, "mask cleared");
        rd(msgq_pkg::PORT_OPFP_OFS, 32'h1234_5678, "host pop");
        idle(3);
        chk({30'h0, host_irq, local_irq}, 32'h0000_0001, "host irq drop");
        acc(1'b1, 1'b1, msgq_pkg::PORT_IPFP_OFS, 32'hCAFE_0001);
        chk(reg_rdata, 32'h8765_4321, "read and write");
        rd(msgq_pkg::PORT_IFPP_OFS, 32'hCAFE_0001, "same cycle push");
        idle(3);
        chk({30'h0, host_irq, local_irq}, 32'h0000_0000, "irq idle");
        $display("test status_irq done");
        for (int p = 0; p < 4; p++) begin
            acc(1'b0, 1'b1, wr_port[p], 32'h5A5A_0000);
        end
        acc(1'b0, 1'b1, msgq_pkg::HOST_MASK_OFS, 32'h0000_0000);
        rst_in = 1'b1;
        idle(2);
        rst_in = 1'b0;
        reset_state();
        $display("test mid_reset done");
        results();
    end

    initial begin
        #1000000;
        err_total++;
        $display("MISMATCH %0t run timed out", $time);
        results();
    end
endmodule
